// File: logic/cjb_core.sv
// Collision jam, backoff counters and registers of the serial channel.
`timescale 1ns/100ps
module cjb_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Channel mode bits
  input wire logic backoff_mode_high,
  input wire logic backoff_mode_low,
  input wire logic crc32_sel,
  // Transmitter status
  input wire logic tx_active,
  input wire logic tx_preamble_flag,
  input wire logic tx_fifo_taken,
  input wire logic tx_data,
  input wire logic [31:0] tx_crc,
  // Line status from the receiver
  input wire logic collision_det,
  input wire logic line_idle,
  input wire logic ifs_expired,
  // Line pins
  input wire logic rx_line_pin,
  output logic tx_line_pin,
  // Results
  output logic jam_active,
  output logic transmit_enable_bit,
  output logic tx_permit,
  output logic restart_window,
  output logic restart_req
);
  import cjb_pkg::*;
  `include "cjb_consts.svh"

  // ==========================================================
  // Declarations
  cjb_state_e state_reg, state_next;
  logic [2:0] div_reg;
  logic [2:0] rx_sync_reg;
  logic rx_stable_reg, ten_reg, err_reg, abort_reg, jam_on_reg, jam_bit_reg;
  cjb_byte_t slot_reg, ccount_reg, backoff_countdown_reg;
  cjb_byte_t stime_rel_reg, stime_cnt_reg, rdata_reg;
  logic [5:0] jam_cnt_reg;
  logic [31:0] crc_hold_reg;
  cjb_byte_t pseudo_random_value, ccount_next, backoff_countdown_next;
  logic bit_tick, slot_tick, rx_act;
  logic det_mode, alt_mode, dc_jam_select;
  logic counting, col_tx, col_restart, col_idle, load_evt;
  logic overflow, abort_now, jam_tick, bk_done;
  logic wr_slot, wr_ccnt, wr_pseudo_random_value, wr_stime, wr_stat;

  // ==========================================================
  // Bit time and pin sampling
  // eight clocks per bit
  assign bit_tick = (div_reg == 3'h7);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // The first sampling stage feeds only the second one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sync_reg <= 3'h7;
      rx_stable_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_line_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_stable_reg <= rx_sync_reg[2];
      end
    end
  end

  assign rx_act = (rx_sync_reg[1] == rx_sync_reg[2]) &&
                  (rx_sync_reg[2] != rx_stable_reg);

  // ==========================================================
  // Mode decode and events
  // algorithm select
  assign det_mode = slot_reg[`CJB_DCR_BIT] & backoff_mode_high &
                    backoff_mode_low;
  assign alt_mode = !slot_reg[`CJB_DCR_BIT] & backoff_mode_high &
                    backoff_mode_low;
  assign dc_jam_select = slot_reg[`CJB_DCJ_BIT];

  assign counting = (state_reg == CJB_QUIET) || (state_reg == CJB_WIFS) ||
                    (state_reg == CJB_BOFF);
  assign col_tx = collision_det && tx_active &&
                  (state_reg == CJB_IDLE || counting);
  assign col_restart = collision_det && !tx_active && det_mode && counting;
  assign col_idle = collision_det && !tx_active && det_mode &&
                    (state_reg == CJB_IDLE);
  assign load_evt = col_tx || col_restart || col_idle;

  // shift a one in, except in deterministic mode
  assign ccount_next = det_mode ? ccount_reg : {ccount_reg[6:0], 1'b1};
  assign overflow = !det_mode && ccount_reg[7];
  assign abort_now = col_tx && (overflow || tx_fifo_taken);

  // ==========================================================
  // Register decode
  assign wr_slot = reg_wr && (reg_addr == `CJB_OFF_SLOT);
  assign wr_ccnt = reg_wr && (reg_addr == `CJB_OFF_CCNT);
  assign wr_pseudo_random_value = reg_wr && (reg_addr == `CJB_OFF_PSEUDO_RANDOM_VALUE);
  assign wr_stime = reg_wr && (reg_addr == `CJB_OFF_STIME);
  assign wr_stat = reg_wr && (reg_addr == `CJB_OFF_TXSTAT);
  // LFSR stepped per bit while slot bit 6 (deterministic select) is clear
  // value held in deterministic mode until rewritten
  cjb_prng cjb_prng_inst (
    .clk(clk),
    .rst_b(rst_b),
    .step(bit_tick && !slot_reg[`CJB_DCR_BIT]),
    .load(wr_pseudo_random_value),
    .load_val(reg_wdata),
    .value(pseudo_random_value)
  );

  // ==========================================================
  // Sequence control
  assign jam_tick = bit_tick && ((state_reg == CJB_JAM) ||
                    (state_reg == CJB_PEND && !tx_preamble_flag));
  // slot tick when the slot clock is at one
  assign slot_tick = bit_tick && (state_reg == CJB_BOFF) &&
                     (stime_cnt_reg == 8'h01);
  // deterministic zero keeps its slot before release
  assign bk_done = (backoff_countdown_reg == 8'h00) && (!det_mode || slot_tick);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CJB_IDLE: begin
        // wait for preamble and flag to end
        if (col_tx) begin
          state_next = tx_preamble_flag ? CJB_PEND : CJB_JAM;
        end else if (col_idle) begin
          state_next = CJB_QUIET;
        end
      end
      CJB_PEND: begin
        if (jam_tick) begin
          state_next = CJB_JAM;
        end
      end
      CJB_JAM: begin
        // after the jam wait for quiet, or go idle on abort
        if (bit_tick && jam_cnt_reg == 6'h00) begin
          state_next = abort_reg ? CJB_IDLE : CJB_QUIET;
        end
      end
      CJB_QUIET: begin
        // normal mode counts at idle, others wait for space
        if (col_tx) begin
          state_next = tx_preamble_flag ? CJB_PEND : CJB_JAM;
        end else if (col_restart) begin
          state_next = CJB_QUIET;
        end else if (line_idle) begin
          state_next = (det_mode || alt_mode) ? CJB_WIFS : CJB_BOFF;
        end
      end
      CJB_WIFS: begin
        if (col_tx) begin
          state_next = tx_preamble_flag ? CJB_PEND : CJB_JAM;
        end else if (col_restart) begin
          state_next = CJB_QUIET;
        end else if (ifs_expired) begin
          state_next = CJB_BOFF;
        end
      end
      CJB_BOFF: begin
        if (col_tx) begin
          state_next = tx_preamble_flag ? CJB_PEND : CJB_JAM;
        end else if (col_restart || (det_mode && rx_act)) begin
          state_next = CJB_QUIET;
        end else if (bk_done) begin
          state_next = CJB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CJB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Jam generator
  // length follows the CRC size
  // DC low or inverted CRC, MSB first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jam_cnt_reg <= 6'h00;
      crc_hold_reg <= 32'h0000_0000;
      jam_on_reg <= 1'b0;
      jam_bit_reg <= 1'b1;
      abort_reg <= 1'b0;
    end else if (col_tx) begin
      jam_cnt_reg <= crc32_sel ? `CJB_JAM32 : `CJB_JAM16;
      crc_hold_reg <= tx_crc;
      abort_reg <= abort_now;
    end else if (jam_tick) begin
      jam_on_reg <= (jam_cnt_reg != 6'h00);
      jam_bit_reg <= dc_jam_select ? 1'b0 :
                     ~crc_hold_reg[5'(jam_cnt_reg - 6'h01)];
      if (jam_cnt_reg != 6'h00) begin
        jam_cnt_reg <= jam_cnt_reg - 6'h01;
      end
    end
  end
  assign jam_active = jam_on_reg;
  assign tx_line_pin = jam_on_reg ? jam_bit_reg : tx_data;

  // ==========================================================
  // Backoff and slot counters
  // load count AND pseudo-random value
  // drop once per slot while nonzero
  assign backoff_countdown_next = load_evt ? (ccount_next & pseudo_random_value) :
                      (slot_tick && backoff_countdown_reg != 8'h00) ?
                      backoff_countdown_reg - 8'h01 : backoff_countdown_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      backoff_countdown_reg <= 8'h00;
      stime_cnt_reg <= `CJB_STIME_RST;
    end else begin
      backoff_countdown_reg <= backoff_countdown_next;
      // reload at one, zero reload runs 256 bits
      if (load_evt || slot_tick) begin
        stime_cnt_reg <= stime_rel_reg;
      end else if (bit_tick && state_reg == CJB_BOFF) begin
        stime_cnt_reg <= stime_cnt_reg - 8'h01;
      end
    end
  end

  // ==========================================================
  // Software registers
  // Hardware events win over a write in the same cycle, except the LFSR step, which a pseudo-random value write overrides.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_reg <= `CJB_SLOT_RST;
      ccount_reg <= `CJB_CCNT_RST;
      stime_rel_reg <= `CJB_STIME_RST;
      ten_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      // slot in low six bits, jam and mode bits above
      if (wr_slot) begin
        slot_reg <= reg_wdata;
      end
      // software may set the highest slot here
      if (col_tx || col_restart || col_idle) begin
        ccount_reg <= ccount_next;
      end else if (wr_ccnt) begin
        ccount_reg <= reg_wdata;
      end
      // writes reach only the reload value
      if (wr_stime) begin
        stime_rel_reg <= reg_wdata;
      end
      // clear enable and flag the error
      if (abort_now) begin
        ten_reg <= 1'b0;
        err_reg <= 1'b1;
      end else if (wr_stat) begin
        ten_reg <= reg_wdata[`CJB_TEN_BIT];
        err_reg <= err_reg & ~reg_wdata[`CJB_ERR_BIT];
      end
    end
  end
  // reads see the live slot count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CJB_OFF_SLOT: rdata_reg <= slot_reg;
        `CJB_OFF_CCNT: rdata_reg <= ccount_reg;
        `CJB_OFF_PSEUDO_RANDOM_VALUE: rdata_reg <= pseudo_random_value;
        `CJB_OFF_BACKOFF_COUNTDOWN: rdata_reg <= backoff_countdown_reg;
        `CJB_OFF_STIME: rdata_reg <= stime_cnt_reg;
        `CJB_OFF_TXSTAT: rdata_reg <= {6'h00, err_reg, ten_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Restart control
  // window while the count equals the own slot in deterministic mode, else at zero
  assign restart_window = (state_reg == CJB_BOFF) && (det_mode ?
                          (backoff_countdown_reg == {2'h0, slot_reg[5:0]}) :
                          (backoff_countdown_reg == 8'h00));
  assign restart_req = (state_reg == CJB_BOFF) && bk_done &&
                       !col_tx && !rx_act && !abort_reg;
  assign transmit_enable_bit = ten_reg;
  // no transmit while the count is nonzero, except in the deterministic own-slot window
  assign tx_permit = ten_reg && !jam_on_reg && (restart_window ||
                     (state_reg == CJB_IDLE && backoff_countdown_reg == 8'h00));

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [5:0] jam_len_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jam_len_reg <= 6'h00;
    end else if (col_tx) begin
      jam_len_reg <= 6'h00;
    end else if (jam_tick && jam_cnt_reg != 6'h00) begin
      jam_len_reg <= jam_len_reg + 6'h01;
    end
  end
  sequence s_bit_gap;
    !bit_tick [*7] ##1 bit_tick;
  endsequence
  a_bit_period: assert property (bit_tick |=> s_bit_gap)
    else $error("bit time is not eight clocks");
  a_jam_next: assert property (col_tx && !tx_preamble_flag |=>
    state_reg == CJB_JAM ##[1:8] jam_on_reg)
    else $error("jam did not start in the next bit time");
  a_jam_length: assert property ($fell(jam_on_reg) |->
    jam_len_reg == (crc32_sel ? `CJB_JAM32 : `CJB_JAM16))
    else $error("jam length differs from CRC length");
  a_dc_jam: assert property (jam_on_reg && dc_jam_select |-> !tx_line_pin)
    else $error("DC jam did not hold the line low");
  a_count_shift: assert property (col_tx && !det_mode |=>
    ccount_reg == {$past(ccount_reg[6:0]), 1'b1})
    else $error("collision count not shifted");
  a_det_hold: assert property (col_tx && det_mode |=>
    $stable(ccount_reg))
    else $error("deterministic collision changed the count");
  a_backoff_countdown_load: assert property (load_evt |=>
    backoff_countdown_reg == ($past(ccount_next) & $past(pseudo_random_value)))
    else $error("backoff load is not count AND random");
  a_abort_flags: assert property (abort_now |=>
    !ten_reg && err_reg ##1 1'b1)
    else $error("abort did not clear enable and set error");
  a_slot_reload: assert property (slot_tick && !load_evt |=>
    stime_cnt_reg == $past(stime_rel_reg))
    else $error("slot clock did not reload");
  a_quiet_wait: assert property (state_reg == CJB_QUIET &&
    !line_idle && !collision_det |=> state_reg == CJB_QUIET)
    else $error("backoff began before the line went idle");
  a_det_freeze: assert property (state_reg == CJB_QUIET && det_mode &&
    !load_evt |=> $stable(backoff_countdown_reg))
    else $error("frozen countdown moved");
endmodule

// File: inc/cjb_consts.svh
// Constants of the collision jam and backoff block.
// How it works
// - Transmitting and a collision seen on receive: send jam to all stations.
// - Collision in preamble or flag: finish them, jam from next bit time.
// - Collision after the flag: jam starts in the next bit time.
// - Jam lasts as many bit times as the CRC length, 16 or 32.
// - DC jam holds the line low; otherwise send the inverted CRC so far.
// - After the jam go idle; backoff starts once receive line is idle.
// - Three bits pick normal random, alternate random or deterministic.
// - Random modes shift a one into the collision count from the right.
// - Backoff counter loads collision count AND pseudo-random value.
// - Counter drops each slot, is read only, blocks transmit while nonzero outside the deterministic own-slot window.
// - Count overflow or FIFO touched: clear enable, flag error, no restart.
// - Normal mode counts at line idle; alternate waits for interframe space.
// - Slot clock counts bit times, ticks at one, reloads; zero gives 256.
// - Slot time writes set reload only; reads return the live count.
// - Slot assignment holds slot 0..63 plus DC jam and deterministic bits.
// - Deterministic: no shift, still AND load, count after interframe space.
// - Software loads all ones; the value holds until reset or rewrite.
// - Counter equal to own slot opens the restart window for one slot.
// - Deterministic: receive activity freezes the count until idle and space.
// - Collision during deterministic countdown restarts the whole sequence.
// - Slot zero is nobody's; it contends when the counter reaches zero.
// - A bit time is eight clocks from reset on.
`ifndef CJB_CONSTS_SVH
`define CJB_CONSTS_SVH

// ==========================================================
// Register offsets
`define CJB_OFF_SLOT 3'h0
`define CJB_OFF_CCNT 3'h1
`define CJB_OFF_PSEUDO_RANDOM_VALUE 3'h2
`define CJB_OFF_BACKOFF_COUNTDOWN 3'h3
`define CJB_OFF_STIME 3'h4
`define CJB_OFF_TXSTAT 3'h5

// ==========================================================
// Field positions
`define CJB_DCJ_BIT 7
`define CJB_DCR_BIT 6
`define CJB_TEN_BIT 0
`define CJB_ERR_BIT 1

// ==========================================================
// Reset values
`define CJB_SLOT_RST 8'h00
`define CJB_CCNT_RST 8'h00
`define CJB_PSEUDO_RANDOM_VALUE_RST 8'hff
`define CJB_STIME_RST 8'h00

// ==========================================================
// Timing
`define CJB_CLK_NS 10
`define CJB_BIT_CLKS 8
`define CJB_JAM16 6'h10
`define CJB_JAM32 6'h20

`endif

// File: inc/cjb_pkg.sv
// Types of the collision jam and backoff block.
package cjb_pkg;

  // Gray codes along idle, jam, quiet, wait space, backoff.
  typedef enum logic [2:0] {
    CJB_IDLE = 3'h0,
    CJB_PEND = 3'h4,
    CJB_JAM = 3'h1,
    CJB_QUIET = 3'h3,
    CJB_WIFS = 3'h2,
    CJB_BOFF = 3'h6
  } cjb_state_e;

  typedef logic [7:0] cjb_byte_t;

endpackage

// File: logic/cjb_prng.sv
// Pseudo-random byte source for the backoff load.
`timescale 1ns/100ps
module cjb_prng (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic step,
  input wire logic load,
  input wire cjb_pkg::cjb_byte_t load_val,
  // Value
  output cjb_pkg::cjb_byte_t value
);
  import cjb_pkg::*;
  `include "cjb_consts.svh"

  cjb_byte_t value_reg;
  cjb_byte_t value_next;
  logic fb;

  // Taps 8, 6, 5, 4 give a maximal sequence of 255 states.
  assign fb = value_reg[7] ^ value_reg[5] ^ value_reg[4] ^ value_reg[3];
  assign value_next = load ? load_val :
                      step ? {value_reg[6:0], fb} : value_reg;
  assign value = value_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_reg <= `CJB_PSEUDO_RANDOM_VALUE_RST;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule

// File: testbench/cjb_station.sv
// Model of the other stations and the line monitor on the shared line.
`timescale 1ns/100ps
module cjb_station #(
  parameter int IFS_CLKS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Our station's drive
  input wire logic tx_line_pin,
  input wire logic jam_active,
  // Bench commands
  input wire logic collide,
  input wire logic busy,
  // Line view
  output logic rx_line_pin,
  output logic collision_det,
  output logic line_idle,
  output logic ifs_expired
);
  logic [8:0] quiet_reg;
  logic [2:0] phase_reg;
  logic other_drv;

  // ==========================================================
  // Line level
  // A busy station sends a square wave, so the line never looks idle.
  assign other_drv = busy ? phase_reg[2] : 1'b1;
  assign rx_line_pin = tx_line_pin & other_drv;

  // ==========================================================
  // Idle and spacing
  // idle then space.
  assign line_idle = (quiet_reg >= 9'h010);
  assign ifs_expired = (quiet_reg >= 9'(16 + IFS_CLKS));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_reg <= 9'h000;
      phase_reg <= 3'h0;
      collision_det <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      collision_det <= collide;
      if (busy || jam_active) begin
        quiet_reg <= 9'h000;
      end else if (quiet_reg != 9'h1ff) begin
        quiet_reg <= quiet_reg + 9'h001;
      end
    end
  end
endmodule

// File: testbench/cjb_core_tb_top.sv
// Self-checking testbench of the collision jam and backoff block.
`timescale 1ns/100ps
`define CJB_CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cjb_core_tb_top;
  import cjb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic backoff_mode_high = 1'b0;
  logic backoff_mode_low = 1'b0;
  logic crc32_sel = 1'b0;
  logic tx_active = 1'b0;
  logic tx_preamble_flag = 1'b0;
  logic tx_fifo_taken = 1'b0;
  logic tx_data = 1'b1;
  logic [31:0] tx_crc = 32'h0000_0000;
  logic collision_det, line_idle, ifs_expired, rx_line_pin, tx_line_pin;
  logic jam_active, transmit_enable_bit, tx_permit;
  logic restart_window, restart_req;
  logic collide = 1'b0;
  logic busy = 1'b0;
  int fails = 0;
  int checked = 0;

  always #5 clk = ~clk;

  cjb_core cjb_core_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .backoff_mode_high(backoff_mode_high),
    .backoff_mode_low(backoff_mode_low), .crc32_sel(crc32_sel),
    .tx_active(tx_active), .tx_preamble_flag(tx_preamble_flag),
    .tx_fifo_taken(tx_fifo_taken), .tx_data(tx_data), .tx_crc(tx_crc),
    .collision_det(collision_det), .line_idle(line_idle),
    .ifs_expired(ifs_expired), .rx_line_pin(rx_line_pin),
    .tx_line_pin(tx_line_pin), .jam_active(jam_active),
    .transmit_enable_bit(transmit_enable_bit), .tx_permit(tx_permit),
    .restart_window(restart_window), .restart_req(restart_req));

  cjb_station cjb_station_inst (.clk(clk), .rst_b(rst_b),
    .tx_line_pin(tx_line_pin), .jam_active(jam_active),
    .collide(collide), .busy(busy), .rx_line_pin(rx_line_pin),
    .collision_det(collision_det), .line_idle(line_idle),
    .ifs_expired(ifs_expired));

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apply_reset();
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand from the cycle after the strobe until the next read.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CJB_CHK(reg_rdata, e)
    @(posedge clk);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return jam_active;
      1: return restart_window;
      default: return restart_req;
    endcase
  endfunction

  // Outputs are judged at falling edges, away from the launching edge.
  task automatic wait_sig(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        fails++;
        report_and_stop();
      end
    end while (sig(k) !== 1'b1);
  endtask

  task automatic high_len(input int k, output int n);
    n = 0;
    while (sig(k) === 1'b1) begin
      n++;
      if (n > 2000) begin
        fails++;
        report_and_stop();
      end
      @(negedge clk);
    end
  endtask

  task automatic quiet(input int k, input int cycles, output logic seen);
    seen = 1'b0;
    repeat (cycles) begin
      @(negedge clk);
      seen = seen | (sig(k) === 1'b1);
    end
    @(posedge clk);
  endtask

  // Samples each jam bit in the middle of its bit time.
  task automatic watch_jam(output int w, output int n,
                           output logic [31:0] bits);
    wait_sig(0, 40, w);
    n = 0;
    bits = 32'h0000_0000;
    while (jam_active === 1'b1 && n < 300) begin
      if (n % 8 == 3) begin
        bits = {bits[30:0], tx_line_pin};
      end
      n++;
      @(negedge clk);
    end
    if (n >= 300) begin
      fails++;
      report_and_stop();
    end
    @(posedge clk);
  endtask

  task automatic hit();
    collide <= 1'b1;
    @(posedge clk);
    collide <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    apply_reset();
    wr(3'h0, 8'h40);
    rd_chk(3'h2, 8'hff);
    rd_chk(3'h0, 8'h40);
    rd_chk(3'h1, 8'h00);
    rd_chk(3'h4, 8'h00);
    wr(3'h3, 8'h55);
    rd_chk(3'h3, 8'h00);
    wr(3'h4, 8'h07);
    rd_chk(3'h4, 8'h00);
    wr(3'h0, 8'hbf);
    rd_chk(3'h0, 8'hbf);
    rd_chk(3'h6, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_jam(input logic dc, input logic c32, input logic pre,
                       input logic alt);
    int w, n;
    logic [31:0] bits, exp;
    logic seen;
    apply_reset();
    wr(3'h0, {dc, 7'h00});
    wr(3'h2, 8'h00);
    wr(3'h5, 8'h01);
    crc32_sel <= c32;
    tx_crc <= 32'ha5c3_0f96;
    tx_active <= 1'b1;
    tx_preamble_flag <= pre;
    backoff_mode_high <= alt;
    backoff_mode_low <= alt;
    busy <= 1'b1;
    hit();
    if (pre) begin
      quiet(0, 40, seen);
      `CJB_CHK(seen, 1'b0)
      tx_preamble_flag <= 1'b0;
    end
    watch_jam(w, n, bits);
    `CJB_CHK(w <= 12, 1'b1)
    `CJB_CHK(n, c32 ? 256 : 128)
    exp = dc ? 32'h0000_0000 : ~32'ha5c3_0f96;
    if (!c32) begin
      exp = {16'h0000, exp[15:0]};
    end
    `CJB_CHK(bits, exp)
    tx_active <= 1'b0;
    rd_chk(3'h1, 8'h01);
    rd_chk(3'h3, 8'h00);
    quiet(2, 40, seen);
    `CJB_CHK(seen, 1'b0)
    busy <= 1'b0;
    wait_sig(2, 200, w);
    `CJB_CHK(w > 64, alt)
    `CJB_CHK(transmit_enable_bit, 1'b1)
    @(negedge clk);
    `CJB_CHK(tx_permit, 1'b1)
    @(posedge clk);
    $display("test jam done");
  endtask

  task automatic t_abort(input logic fifo);
    int w, n;
    logic [31:0] bits;
    logic seen;
    apply_reset();
    wr(3'h1, fifo ? 8'h00 : 8'hff);
    // A zero backoff would restart at once if the abort were lost.
    wr(3'h2, 8'h00);
    wr(3'h5, 8'h01);
    tx_fifo_taken <= fifo;
    tx_active <= 1'b1;
    hit();
    watch_jam(w, n, bits);
    tx_active <= 1'b0;
    tx_fifo_taken <= 1'b0;
    rd_chk(3'h5, 8'h02);
    quiet(2, 300, seen);
    `CJB_CHK(seen, 1'b0)
    `CJB_CHK(transmit_enable_bit, 1'b0)
    $display("test abort done");
  endtask

  task automatic t_det();
    int w, n;
    logic [31:0] bits;
    apply_reset();
    wr(3'h0, 8'h42);
    backoff_mode_high <= 1'b1;
    backoff_mode_low <= 1'b1;
    wr(3'h1, 8'h03);
    wr(3'h2, 8'hff);
    wr(3'h4, 8'h02);
    wr(3'h5, 8'h01);
    tx_active <= 1'b1;
    busy <= 1'b1;
    hit();
    watch_jam(w, n, bits);
    tx_active <= 1'b0;
    repeat (200) @(posedge clk);
    rd_chk(3'h1, 8'h03);
    rd_chk(3'h3, 8'h03);
    rd_chk(3'h2, 8'hff);
    busy <= 1'b0;
    wait_sig(1, 600, w);
    high_len(1, n);
    `CJB_CHK(n, 16)
    `CJB_CHK(tx_permit, 1'b0)
    @(posedge clk);
    rd_chk(3'h3, 8'h01);
    hit();
    @(posedge clk);
    rd_chk(3'h3, 8'h03);
    $display("test deterministic done");
  endtask

  initial begin
    t_regs();
    t_jam(1'b1, 1'b0, 1'b0, 1'b0);
    t_jam(1'b0, 1'b1, 1'b1, 1'b0);
    t_jam(1'b0, 1'b0, 1'b0, 1'b1);
    t_abort(1'b0);
    t_abort(1'b1);
    t_det();
    report_and_stop();
  end
endmodule
